/* pllr_pkg.sv */
// constants for the pulse lock loop register bank
package pllr_pkg;
  // register byte addresses, multi-byte registers most significant byte first
  localparam logic [7:0] ADDR_EVENT_HI    = 8'h07;
  localparam logic [7:0] ADDR_EVENT_LO    = 8'h08;
  localparam logic [7:0] ADDR_STATE       = 8'h20;
  localparam logic [7:0] ADDR_EXTRA       = 8'h21;
  localparam logic [7:0] ADDR_RAW_PHASE   = 8'h23;
  localparam logic [7:0] ADDR_CAL_PHASE   = 8'h29;
  localparam logic [7:0] ADDR_FREQ_OFFSET = 8'h2F;
  localparam logic [7:0] ADDR_START       = 8'h35;
  localparam logic [7:0] ADDR_MANUAL_CTRL = 8'h36;
  localparam logic [7:0] ADDR_ACQ_PARAMS  = 8'h37;
  localparam logic [7:0] ADDR_SOAK_HI     = 8'h38;
  localparam logic [7:0] ADDR_SOAK_LO     = 8'h39;
  localparam logic [7:0] ADDR_PHASE_PARAMS = 8'h3A;
  // loop state codes
  localparam logic [2:0] CODE_HOLDOVER    = 3'h0;
  localparam logic [2:0] CODE_FREQ_ACQ    = 3'h1;
  localparam logic [2:0] CODE_FAST_PHASE  = 3'h3;
  localparam logic [2:0] CODE_NARROWING   = 3'h4;
  localparam logic [2:0] CODE_LOCKED      = 3'h5;
  // field positions
  localparam int STATE_DONE_BIT   = 7;
  localparam int EXTRA_FLAG_BIT   = 15;
  localparam int ACQ_BW_LSB       = 0;
  localparam int ACQ_TOL_LSB      = 2;
  localparam int PH_BW_LSB        = 0;
  localparam int PH_DAMP_LSB      = 6;
  // reset values and codes
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [15:0] RESET_HALF      = 16'h0000;
  localparam logic [47:0] RESET_WIDE      = 48'h0000_0000_0000;
  localparam logic [7:0]  MANUAL_HOLDOVER = 8'h01;
  localparam logic [7:0]  START_PIN_THREE = 8'h03;
  // acquisition filter bandwidths in units of 0.1 mHz
  localparam logic [11:0] FLL_BW_0 = 12'h6FE; // 179 mHz
  localparam logic [11:0] FLL_BW_1 = 12'h384; // 90 mHz
  localparam logic [11:0] FLL_BW_2 = 12'h1C2; // 45 mHz
  localparam logic [11:0] FLL_BW_3 = 12'h0E1; // 22.5 mHz
  localparam logic [15:0] PPT_PER_PPB = 16'h03E8;
  // timing
  localparam int  CLK_HZ = 20_000_000;
  localparam real SECOND_S = 1.0;
  localparam int  CYCLES_PER_SECOND = int'(SECOND_S * CLK_HZ);
endpackage

/* pllr_regs.sv */
// register bank and sequencer of the pulse lock loop
`timescale 1ns/1ps
module pllr_regs #(
  parameter int SECOND_CYCLES = pllr_pkg::CYCLES_PER_SECOND
) (
  input  wire logic        clk,               // 20 MHz master clock
  input  wire logic        rst_b,             // synchronous reset, active low
  input  wire logic        ce,                // clock enable, freezes all state when low
  input  wire logic [7:0]  reg_addr,          // register byte address
  input  wire logic [7:0]  reg_wdata,         // write byte
  input  wire logic        reg_wr,            // write strobe
  input  wire logic        reg_rd,            // read strobe
  input  wire logic [2:0]  ref_in,            // reference inputs one to three
  input  wire logic [47:0] meas_phase,        // measured phase error, 10 ps
  input  wire logic [47:0] meas_freq,         // measured output offset, ppt
  input  wire logic [47:0] detector_calibration_value, // detector calibration, 10 ps
  input  wire logic [47:0] rebuild_bias,      // phase rebuild bias, 10 ps
  input  wire logic [14:0] bucket_level,      // leaky bucket level
  input  wire logic        phase_step,        // phase loop settled, advance state
  output logic      [7:0]  reg_rdata,         // read byte, one cycle after reg_rd
  output logic      [1:0]  ref_select,        // 0 none, 1..3 input pin
  output logic      [11:0] fll_bw,            // filter bandwidth, 0.1 mHz
  output logic      [5:0]  fll_tol_ppb,       // acquisition tolerance, ppb
  output logic      [5:0]  pll_bw_index,      // bandwidth is 1/index Hz
  output logic      [1:0]  pll_damping,       // damping factor select
  output logic      [2:0]  state_code,        // current loop state code
  output logic             state_changed      // pulse on each state change
);

  typedef enum logic [2:0] {ST_HOLD, ST_FREQ, ST_FAST, ST_NARROW, ST_LOCKED} pllr_state_t;

  pllr_state_t state;
  logic [7:0]  start_reg;
  logic [7:0]  manual_ctrl;
  logic [7:0]  acq_params;
  logic [15:0] soak_time;
  logic [7:0]  phase_params;
  logic [15:0] event_reg;
  logic        started;
  logic        comp_done;
  logic [14:0] soak_cnt;
  logic [47:0] raw_phase;
  logic [47:0] cal_phase;
  logic [47:0] freq_offset;
  logic [47:0] freq_min;
  logic [47:0] freq_max;
  logic [2:0]  ref_prev;
  logic [31:0] sec_cnt;
  logic        sec_tick;
  logic        ref_pulse;
  logic        start_wr;
  logic        force_hold;
  logic [2:0]  next_code;
  logic [47:0] pp_span;
  logic [47:0] tol_ppt;
  logic        tol_exceeded;
  logic [7:0]  rd_byte;
  logic [3:0]  rise_vec;
  logic        done_prev;

  //////////////////////////////////////////////////////////////////////////////
  // reference pulse and second timing

  assign start_wr   = reg_wr && reg_addr == pllr_pkg::ADDR_START && reg_wdata != pllr_pkg::RESET_BYTE;
  assign force_hold = manual_ctrl == pllr_pkg::MANUAL_HOLDOVER;
  // rising edges of all pins, slot 0 stands for no pin chosen and never pulses
  assign rise_vec   = {ref_in & ~ref_prev, 1'b0};
  // indexing by the select itself avoids an out-of-range pin index when none is chosen
  assign ref_pulse  = rise_vec[ref_select];
  // a reference pulse marks the second; without a reference the local count does
  assign sec_tick   = (ref_select != 2'h0) ? ref_pulse : (sec_cnt == 32'(SECOND_CYCLES - 1));

  // edge detector history, inputs are already synchronous
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_prev <= 3'h0;
    end else if (ce) begin
      ref_prev <= ref_in;
    end
  end

  // free running second counter for the no-reference case
  // it runs with a pin chosen too, but only counts as a second when none is
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sec_cnt <= 32'h0000_0000;
    end else if (ce) begin
      if (sec_cnt == 32'(SECOND_CYCLES - 1)) begin
        sec_cnt <= 32'h0000_0000;
      end else begin
        sec_cnt <= sec_cnt + 32'h0000_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software written registers
  // writes to read-only or unmapped addresses fall to the default and are dropped

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_reg    <= pllr_pkg::RESET_BYTE;
      manual_ctrl  <= pllr_pkg::RESET_BYTE;
      acq_params   <= pllr_pkg::RESET_BYTE;
      soak_time    <= pllr_pkg::RESET_HALF;
      phase_params <= pllr_pkg::RESET_BYTE;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        pllr_pkg::ADDR_START:        start_reg <= reg_wdata;
        pllr_pkg::ADDR_MANUAL_CTRL:  manual_ctrl <= reg_wdata;
        pllr_pkg::ADDR_ACQ_PARAMS:   acq_params <= reg_wdata;
        pllr_pkg::ADDR_SOAK_HI:      soak_time[15:8] <= reg_wdata;
        pllr_pkg::ADDR_SOAK_LO:      soak_time[7:0] <= reg_wdata;
        pllr_pkg::ADDR_PHASE_PARAMS: phase_params <= reg_wdata; // is software's duty
        default: begin
        end
      endcase
    end
  end

  // input pin choice is taken only on a non-zero start write
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_select <= 2'h0;
      started    <= 1'b0;
    end else if (ce && start_wr) begin
      started    <= 1'b1;
      ref_select <= (reg_wdata <= pllr_pkg::START_PIN_THREE) ? reg_wdata[1:0] : 2'h0;
    end
  end

  // loop parameters presented to the filters
  // one more register stage, so these outputs follow a write two cycles later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fll_bw       <= pllr_pkg::FLL_BW_0;
      fll_tol_ppb  <= 6'h00;
      pll_bw_index <= 6'h00;
      pll_damping  <= 2'h0;
    end else if (ce) begin
      case (acq_params[pllr_pkg::ACQ_BW_LSB +: 2])
        2'h0:    fll_bw <= pllr_pkg::FLL_BW_0;
        2'h1:    fll_bw <= pllr_pkg::FLL_BW_1;
        2'h2:    fll_bw <= pllr_pkg::FLL_BW_2;
        default: fll_bw <= pllr_pkg::FLL_BW_3;
      endcase
      fll_tol_ppb  <= acq_params[pllr_pkg::ACQ_TOL_LSB +: 6];
      pll_bw_index <= phase_params[pllr_pkg::PH_BW_LSB +: 6];
      pll_damping  <= phase_params[pllr_pkg::PH_DAMP_LSB +: 2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // measurements

  // latched once per received pulse, frozen in holdover
  // all three share one strobe, so a read between pulses sees one matching set
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      raw_phase   <= pllr_pkg::RESET_WIDE;
      cal_phase   <= pllr_pkg::RESET_WIDE;
      freq_offset <= pllr_pkg::RESET_WIDE;
    end else if (ce && ref_pulse && state != ST_HOLD) begin
      raw_phase   <= meas_phase;
      cal_phase   <= meas_phase - detector_calibration_value - rebuild_bias;
      freq_offset <= meas_freq;
    end
  end

  // peak-to-peak of the output frequency over the soak, not the in-out offset
  // the tolerance is held in ppb and the offset in ppt, so it is scaled first
  assign pp_span      = freq_max - freq_min;
  assign tol_ppt      = 48'(fll_tol_ppb) * 48'(pllr_pkg::PPT_PER_PPB);
  assign tol_exceeded = pp_span > tol_ppt;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freq_min <= pllr_pkg::RESET_WIDE;
      freq_max <= pllr_pkg::RESET_WIDE;
    end else if (ce) begin
      if (state != ST_FREQ || tol_exceeded) begin
        freq_min <= freq_offset;
        freq_max <= freq_offset;
      end else begin
        if ($signed(freq_offset) < $signed(freq_min)) begin
          freq_min <= freq_offset;
        end
        if ($signed(freq_offset) > $signed(freq_max)) begin
          freq_max <= freq_offset;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // loop sequencer

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state     <= ST_HOLD;
      soak_cnt  <= 15'h0000;
      comp_done <= 1'b0;
    end else if (ce) begin
      // a fresh start write restarts compensation; a lock reached in the same cycle wins
      if (start_wr) begin
        comp_done <= 1'b0;
      end
      case (state)
        // holdover is left once started and not forced, with the soak loaded afresh
        ST_HOLD: begin
          if (started && !force_hold) begin
            state    <= ST_FREQ;
            soak_cnt <= soak_time[14:0];
          end
        end
        ST_FREQ: begin
          if (force_hold) begin
            state <= ST_HOLD;
          end else if (tol_exceeded) begin
            soak_cnt <= soak_time[14:0]; // frequency still moving, soak again
          end else if (soak_cnt == 15'h0000) begin
            state <= ST_FAST;
          end else if (sec_tick) begin
            soak_cnt <= soak_cnt - 15'h0001;
          end
        end
        ST_FAST: begin
          if (force_hold) begin
            state <= ST_HOLD;
          end else if (phase_step) begin
            state <= ST_NARROW;
          end
        end
        ST_NARROW: begin
          if (force_hold) begin
            state <= ST_HOLD;
          end else if (phase_step) begin
            state     <= ST_LOCKED;
            comp_done <= 1'b1;
          end
        end
        ST_LOCKED: begin
          if (force_hold) begin
            state <= ST_HOLD;
          end
        end
        default: state <= ST_HOLD;
      endcase
    end
  end

  // state code as software sees it
  // the code lags the state by one cycle, and the change pulse lines up with it
  always_comb begin
    case (state)
      ST_FREQ:   next_code = pllr_pkg::CODE_FREQ_ACQ;
      ST_FAST:   next_code = pllr_pkg::CODE_FAST_PHASE;
      ST_NARROW: next_code = pllr_pkg::CODE_NARROWING;
      ST_LOCKED: next_code = pllr_pkg::CODE_LOCKED;
      default:   next_code = pllr_pkg::CODE_HOLDOVER;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_code    <= pllr_pkg::CODE_HOLDOVER;
      state_changed <= 1'b0;
    end else if (ce) begin
      state_code    <= next_code;
      state_changed <= next_code != state_code;
    end
  end

  // last compensation flag, so its change also counts as a state register change
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_prev <= 1'b0;
    end else if (ce) begin
      done_prev <= comp_done;
    end
  end

  // event bit 0 sticky; write one clears, a same-cycle change wins
  // only bit 0 is defined, the upper bits stay zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      event_reg <= pllr_pkg::RESET_HALF;
    end else if (ce) begin
      if (reg_wr && reg_addr == pllr_pkg::ADDR_EVENT_LO && reg_wdata[0]) begin
        event_reg[0] <= 1'b0;
      end
      if (next_code != state_code || comp_done != done_prev) begin
        event_reg[0] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    rd_byte = pllr_pkg::RESET_BYTE;
    case (reg_addr)
      pllr_pkg::ADDR_EVENT_HI:     rd_byte = event_reg[15:8];
      pllr_pkg::ADDR_EVENT_LO:     rd_byte = event_reg[7:0];
      pllr_pkg::ADDR_STATE:        rd_byte = {comp_done, 4'h0, state_code};
      // extra info changes meaning with the state; holdover has nothing to show
      pllr_pkg::ADDR_EXTRA,
      pllr_pkg::ADDR_EXTRA + 8'h01: begin
        case (state)
          ST_FREQ: rd_byte = (reg_addr == pllr_pkg::ADDR_EXTRA) ? {1'b0, soak_cnt[14:8]} : soak_cnt[7:0];
          ST_FAST, ST_NARROW, ST_LOCKED:
            rd_byte = (reg_addr == pllr_pkg::ADDR_EXTRA) ? {1'b1, bucket_level[14:8]} : bucket_level[7:0];
          default: rd_byte = pllr_pkg::RESET_BYTE;
        endcase
      end
      pllr_pkg::ADDR_START:        rd_byte = start_reg;
      pllr_pkg::ADDR_MANUAL_CTRL:  rd_byte = manual_ctrl;
      pllr_pkg::ADDR_ACQ_PARAMS:   rd_byte = acq_params;
      pllr_pkg::ADDR_SOAK_HI:      rd_byte = soak_time[15:8];
      pllr_pkg::ADDR_SOAK_LO:      rd_byte = soak_time[7:0];
      pllr_pkg::ADDR_PHASE_PARAMS: rd_byte = phase_params;
      default: begin
        // six-byte fields, most significant byte at the lowest address
        if (reg_addr >= pllr_pkg::ADDR_RAW_PHASE && reg_addr < pllr_pkg::ADDR_CAL_PHASE) begin
          rd_byte = raw_phase[8'(5 - (reg_addr - pllr_pkg::ADDR_RAW_PHASE)) * 8 +: 8];
        end else if (reg_addr >= pllr_pkg::ADDR_CAL_PHASE && reg_addr < pllr_pkg::ADDR_FREQ_OFFSET) begin
          rd_byte = cal_phase[8'(5 - (reg_addr - pllr_pkg::ADDR_CAL_PHASE)) * 8 +: 8];
        end else if (reg_addr >= pllr_pkg::ADDR_FREQ_OFFSET && reg_addr < pllr_pkg::ADDR_START) begin
          rd_byte = freq_offset[8'(5 - (reg_addr - pllr_pkg::ADDR_FREQ_OFFSET)) * 8 +: 8];
        end
      end
    endcase
  end

  // registered read; wide values are not snapshotted, so read them between pulses
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= pllr_pkg::RESET_BYTE;
    end else if (ce && reg_rd) begin
      reg_rdata <= rd_byte;
    end
  end

endmodule

/* pllr_regs_sva.sv */
// port assertions for the pulse lock loop register bank
`timescale 1ns/1ps
module pllr_regs_sva #(
  parameter int SECOND_CYCLES = 20 // tick length, handed on by the bind
) (
  input wire logic        clk,          // clock
  input wire logic        rst_b,        // reset, low
  input wire logic        ce,           // enable
  input wire logic [7:0]  reg_addr,     // address
  input wire logic [7:0]  reg_wdata,    // write byte
  input wire logic        reg_wr,       // write
  input wire logic        phase_step,   // advance
  input wire logic [1:0]  ref_select,   // pin
  input wire logic [11:0] fll_bw,       // bandwidth
  input wire logic [5:0]  fll_tol_ppb,  // tolerance
  input wire logic [5:0]  pll_bw_index, // index
  input wire logic [1:0]  pll_damping,  // damping
  input wire logic [2:0]  state_code,   // state
  input wire logic        state_changed // change pulse
);
  // expected filter bandwidth of the byte being written
  wire logic        wr_go = ce && reg_wr;
  wire logic [1:0]  sel   = reg_wdata[1:0];
  wire logic [11:0] bw    = sel[1] ? (sel[0] ? pllr_pkg::FLL_BW_3 : pllr_pkg::FLL_BW_2)
                                   : (sel[0] ? pllr_pkg::FLL_BW_1 : pllr_pkg::FLL_BW_0);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  legal_state_a: assert property (!(state_code inside {3'h2, 3'h6, 3'h7}))
    else $error("reserved state code");
  change_flag_a: assert property ($changed(state_code) |-> state_changed)
    else $error("state change without pulse");
  pin_select_a: assert property (wr_go && reg_addr == 8'h35 && reg_wdata != 8'h00
    |=> ref_select == ($past(reg_wdata) < 8'h04 ? $past(sel) : 2'h0)) else $error("wrong pin");
  filter_bw_a: assert property (wr_go && reg_addr == 8'h37 ##1 ce |=> fll_bw == $past(bw, 2))
    else $error("wrong filter bandwidth");
  tol_field_a: assert property (wr_go && reg_addr == 8'h37 ##1 ce
    |=> fll_tol_ppb == $past(reg_wdata[7:2], 2)) else $error("wrong tolerance");
  phase_par_a: assert property (wr_go && reg_addr == 8'h3A ##1 ce
    |=> {pll_damping, pll_bw_index} == $past(reg_wdata, 2)) else $error("wrong phase parameters");
  manual_hold_a: assert property (wr_go && reg_addr == 8'h36 && reg_wdata == 8'h01
    |-> ##[1:3] state_code == 3'h0) else $error("manual holdover not entered");
  narrow_step_a: assert property (ce && phase_step && state_code == 3'h3
    |-> ##[1:3] state_code == 3'h4) else $error("no step to narrowing");
  // main scenarios reached
  cover property (state_code == 3'h5);
  cover property (wr_go && reg_addr == 8'h36 && reg_wdata == 8'h01);
  cover property (state_changed);
endmodule
bind pllr_regs pllr_regs_sva #(.SECOND_CYCLES(SECOND_CYCLES)) u_sva (.clk, .rst_b, .ce, .reg_addr, .reg_wdata,
  .reg_wr, .phase_step, .ref_select, .fll_bw, .fll_tol_ppb, .pll_bw_index, .pll_damping, .state_code,
  .state_changed);

/* pllr_pps_src.sv */
// reference pulse source with phase and frequency readings
`timescale 1ns/1ps
module pllr_pps_src (
  input  wire logic        clk,        // master clock
  input  wire logic        rst_b,      // reset, low
  input  wire logic [2:0]  pin_en,     // pins that pulse
  input  wire logic [7:0]  period,     // pulse spacing is this plus one cycle
  output logic      [2:0]  ref_in,     // pulse pins, idle low
  output logic      [47:0] meas_phase, // phase, 10 ps
  output logic      [47:0] meas_freq   // offset, ppt
);
  logic [7:0] cnt; // cycles since last pulse
  ////////////////////////////////////////////////////////////////////////////////
  // two-cycle pulses; readings move only with a pulse so a silent source leaves them alone
  always @(posedge clk) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      ref_in <= 3'h0;
      meas_phase <= 48'h0;
      meas_freq <= 48'h0;
    end else begin
      cnt <= (cnt >= period) ? 8'h00 : cnt + 8'h01;
      ref_in <= (cnt < 8'h02) ? pin_en : 3'h0;
      if (cnt == 8'h00 && pin_en != 3'h0) begin
        meas_phase <= 48'({$urandom, $urandom});
        meas_freq <= 48'($urandom_range(0, 999)); // small swing stays inside the tolerance
      end
    end
  end
endmodule

/* tb.sv */
// self-checking bench for the pulse lock loop register bank
`timescale 1ns/1ps
module tb;
  logic        clk, rst_b, ce, reg_wr, reg_rd, phase_step, rd_taken;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, period, v;
  logic [2:0]  ref_in, pin_en, state_code;
  logic [47:0] meas_phase, meas_freq, cal, bias, held;
  logic [14:0] bucket;
  logic [15:0] note;
  logic [15:0] exp_q[$];
  int          fail_count, checked, cycles;
  pllr_regs #(.SECOND_CYCLES(20)) dut (.clk, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .ref_in,
    .meas_phase, .meas_freq, .detector_calibration_value(cal), .rebuild_bias(bias), .bucket_level(bucket),
    .phase_step, .reg_rdata, .ref_select(), .fll_bw(), .fll_tol_ppb(), .pll_bw_index(), .pll_damping(),
    .state_code, .state_changed());
  pllr_pps_src src (.clk, .rst_b, .pin_en, .period, .ref_in, .meas_phase, .meas_freq);
  ////////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
  endtask
  // the read note is queued with the strobe, ahead of the next edge, so the watcher always finds it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick;
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back({a, e});
    tick;
    reg_rd = 1'b0;
  endtask
  task automatic rd_wide(input logic [7:0] a, input logic [47:0] w);
    for (int i = 0; i < 6; i++) begin
      rd(a + 8'(i), w[47 - 8 * i -: 8]);
    end
  endtask
  task automatic wait_state(input logic [2:0] c);
    int n;
    n = 0;
    while (state_code !== c && n < 3000) begin
      tick;
      n++;
    end
    checked++;
    if (state_code !== c) begin
      fail_count++;
      $display("Error state_code expected %0d seen %0d", c, state_code);
    end
  endtask
  task automatic close_out;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watcher: read data lands one edge after the strobe, so it is compared at the falling edge
  always @(posedge clk) rd_taken <= reg_rd && ce && rst_b;
  always @(negedge clk) begin
    if (rd_taken) begin
      note = exp_q.pop_front();
      checked++;
      if (reg_rdata !== note[7:0]) begin
        fail_count++;
        $display("Error reg_rdata at 0x%h expected 0x%h seen 0x%h", note[15:8], note[7:0], reg_rdata);
      end
    end
  end
  // hang guard, well above the several hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      $display("Error timeout at cycle %0d", cycles);
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h1AE3));
    {ce, rst_b, reg_wr, reg_rd, phase_step} = 5'h10;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pin_en = 3'h1;
    period = 8'h1E;
    cal = 48'({$urandom, $urandom});
    bias = 48'($urandom);
    bucket = 15'($urandom);
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 6; i++) rd(8'h35 + 8'(i), 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    rd(8'h50, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = (8'($urandom) & 8'hFC) | 8'(i);
      wr(8'h37, v);
      rd(8'h37, v);
    end
    v = {2'($urandom), 6'($urandom_range(10, 63))};
    wr(8'h3A, v);
    rd(8'h3A, v);
    wr(8'h37, 8'hFC);
    wr(8'h39, 8'h03);
    rd(8'h39, 8'h03);
    wr(8'h35, 8'h02);
    wait_state(3'h1);
    rd(8'h22, 8'h03);
    repeat (100) tick;
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h03);
    pin_en = 3'h2;
    wait_state(3'h3);
    rd(8'h21, {1'b1, bucket[14:8]});
    rd(8'h22, bucket[7:0]);
    @(posedge ref_in[1]);
    repeat (3) tick;
    pin_en = 3'h0;
    rd_wide(8'h23, meas_phase);
    rd_wide(8'h29, meas_phase - cal - bias);
    rd_wide(8'h2F, meas_freq);
    for (int i = 0; i < 2; i++) begin
      tick;
      phase_step = 1'b1;
      tick;
      phase_step = 1'b0;
      wait_state(3'h4 + 3'(i));
      rd(8'h20, i ? 8'h85 : 8'h04);
    end
    rd(8'h08, 8'h01);
    wr(8'h08, 8'h01);
    rd(8'h08, 8'h00);
    wr(8'h36, 8'h01);
    wait_state(3'h0);
    held = meas_phase;
    period = 8'h3C;
    pin_en = 3'h2;
    repeat (150) tick;
    pin_en = 3'h0;
    repeat (3) tick;
    rd(8'h20, 8'h80);
    rd_wide(8'h23, held);
    wr(8'h36, 8'h00);
    wr(8'h35, 8'h05);
    wait_state(3'h1);
    rd(8'h20, 8'h01);
    // with the enable low the soak countdown must stand still
    ce = 1'b0;
    repeat (100) tick;
    wait_state(3'h1);
    ce = 1'b1;
    wait_state(3'h3);
    tick;
    close_out;
  end
endmodule
